// *** design/async_serial_flags_baud.sv ***
/*
  Status flags, holding buffers, interrupt request and bit-rate chain of
  an asynchronous serial port, reached over APB.
  Assumes external shifters: the transmit shifter takes the holding byte
  with txTake and reports txLineBusy; the receiver offers a finished
  character with rxCharReady plus its noise and framing results.
*/
// Decided for this implementation: the address map and the APB interface to the registers.
// Functional notes
// - Transmit-empty clears: status read, data write
// - Transmit-done clears: status read, data write
// - Receive-full sets on load, clears by read
// - Idle sets once per busy-idle, not sleeping
// - Idle means one character of ones
// - Overrun keeps old byte, drops new
// - Noise flag set by disagreeing samples
// - Framing flag set by zero stop bit
// - Noise and framing never interrupt
// - Prescaler divides by 1, 3, 4, 13
// - Rate select divides by 1 to 128
// - Sample tick is 16x, bit tick
// - Prescaler resets to divide-by-one
// - Rate select bits survive reset
// - Enabling transmitter from off sets empty and done
// - Interrupt on empty enable and flag
// - Interrupt on done enable and flag
// - Disable finishes character, drops queue
// - Idle disable releases pin on bit tick
// - Last character sets done and empty
// - Only empty, done, full, overrun, idle interrupt
// - Receive interrupt on full or overrun
// - Idle interrupt on quiet enable, flag
// - Sleep inhibits all receive flags
// - Framing flag blocks further loads
`timescale 1ns/10ps
module async_serial_flags_baud (
  // Clock, reset and enable
  input  wire logic        clock,
  input  wire logic        sysRst,
  input  wire logic        ce,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Transmit shifter
  input  wire logic        txLineBusy,
  input  wire logic        txTake,
  output logic             txDataValid,
  output logic      [7:0]  txData,
  output logic             txPinOwn,
  // Receive shifter
  input  wire logic        rxLine,
  input  wire logic        rxCharReady,
  input  wire logic [7:0]  rxCharData,
  input  wire logic        rxNoise,
  input  wire logic        rxFraming,
  // Rate ticks and interrupt
  output logic             sampleTick,
  output logic             bitTick,
  output logic             serialIrq
);
  import serial_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  flg_r;
  logic [7:0]  flg_nxt;
  logic [7:0]  armed_r;
  logic [7:0]  armed_nxt;
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [1:0]  prescale_r;
  logic [1:0]  prescale_nxt;
  logic        rateClear_r;
  logic        rateClear_nxt;
  logic [2:0]  rateSel_r;
  logic [2:0]  rateSel_nxt;
  logic [7:0]  rxBuf_r;
  logic [7:0]  rxBuf_nxt;
  logic [7:0]  txBuf_r;
  logic [7:0]  txBuf_nxt;
  logic        bufValid_r;
  logic        bufValid_nxt;
  logic        busyPrev_r;
  logic        irq_r;
  logic        irq_nxt;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  tx_state_t   txState_r;
  tx_state_t   txState_nxt;
  logic        access;
  logic        mapped;
  logic        statusRd;
  logic        dataRd;
  logic        dataWr;
  logic        clrTx;
  logic        clrRx;
  logic        sleep;
  logic        txEnable;
  logic        teRise;
  logic        lastDone;
  logic        busyFall;
  logic        rxAccept;
  logic        rxLoad;
  logic        idleEvent;

  ////////////////////////////////////////////////////////////////////////
  baud_rate_gen #(
    .RATE_BITS (3)
  ) u_rate (
    .clock        (clock),
    .sysRst       (sysRst),
    .ce           (ce),
    .counterClear (rateClear_r),
    .prescaleSel  (prescale_r),
    .rateSel      (rateSel_r),
    .sampleTick   (sampleTick),
    .bitTick      (bitTick)
  );

  line_idle_detect #(
    .CHAR_TICKS (CHAR_SAMPLES)
  ) u_idle (
    .clock      (clock),
    .sysRst     (sysRst),
    .ce         (ce),
    .sampleTick (sampleTick),
    .rxLine     (rxLine),
    .idleEvent  (idleEvent)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle so prdata is a flop; the
  // access phase therefore completes in one cycle whenever ce is high.
  always_comb begin
    access   = ce && psel && penable;
    mapped   = (paddr == ADDR_STATUS) || (paddr == ADDR_DATA) ||
               (paddr == ADDR_RATE) || (paddr == ADDR_CTRL);
    statusRd = access && !pwrite && (paddr == ADDR_STATUS);
    dataRd   = access && !pwrite && (paddr == ADDR_DATA);
    dataWr   = access && pwrite && (paddr == ADDR_DATA);
    pready   = access;
    pslverr  = access && !mapped;
    prdata   = rdData_r;
    rdData_nxt = rdData_r;
    if (psel && !penable) begin
      if (paddr == ADDR_STATUS) begin
        rdData_nxt = {24'h000000, flg_r};
      end else if (paddr == ADDR_DATA) begin
        rdData_nxt = {24'h000000, rxBuf_r};
      end else if (paddr == ADDR_RATE) begin
        rdData_nxt = {24'h000000, rateClear_r, 1'b0, prescale_r, 1'b0, rateSel_r};
      end else if (paddr == ADDR_CTRL) begin
        rdData_nxt = {24'h000000, ctrl_r};
      end else begin
        rdData_nxt = 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl_nxt      = ctrl_r;
    prescale_nxt  = prescale_r;
    rateClear_nxt = rateClear_r;
    rateSel_nxt   = rateSel_r;
    if (access && pwrite && paddr == ADDR_CTRL) begin
      ctrl_nxt = pwdata[7:0];
    end else if (access && pwrite && paddr == ADDR_RATE) begin
      rateClear_nxt = pwdata[RT_COUNTER_CLEAR];
      prescale_nxt  = pwdata[RT_PRESCALE_LO +: 2];
      rateSel_nxt   = pwdata[RT_DIVIDER_LO +: 3];
    end
    sleep    = ctrl_r[CT_RECEIVER_SLEEP];
    txEnable = ctrl_r[CT_TX_ENABLE];
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit side: pin ownership, holding buffer and disable drain.
  always_comb begin
    txState_nxt = txState_r;
    teRise      = 1'b0;
    busyFall    = busyPrev_r && !txLineBusy;
    case (txState_r)
      TX_OFF: begin
        if (txEnable) begin
          txState_nxt = TX_ON;
          teRise      = 1'b1;
        end
      end
      TX_ON: begin
        if (!txEnable) begin
          txState_nxt = TX_DRAIN;
        end
      end
      default: begin
        if (txEnable) begin
          txState_nxt = TX_ON;
        end else if (!txLineBusy && bitTick) begin
          txState_nxt = TX_OFF;
        end
      end
    endcase
    lastDone = (txState_r == TX_DRAIN) && busyFall;
    txBuf_nxt    = txBuf_r;
    bufValid_nxt = bufValid_r;
    if (txTake) begin
      bufValid_nxt = 1'b0;
    end
    if (dataWr && txState_r == TX_ON) begin
      txBuf_nxt    = pwdata[7:0];
      bufValid_nxt = 1'b1;
    end
    if (txState_r != TX_ON) begin
      bufValid_nxt = 1'b0;
    end
    txDataValid = bufValid_r && (txState_r == TX_ON);
    txData      = txBuf_r;
    txPinOwn    = (txState_r != TX_OFF);
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags. A flag is cleared only if the status read saw it set; a set in
  // the same cycle as the clear wins, so no event is lost.
  always_comb begin
    clrTx     = dataWr;
    clrRx     = dataRd;
    armed_nxt = armed_r;
    if (statusRd) begin
      armed_nxt = armed_r | rdData_r[7:0];
    end
    if (clrTx) begin
      armed_nxt = armed_nxt & ~TX_FLAG_MASK;
    end
    if (clrRx) begin
      armed_nxt = armed_nxt & ~RX_FLAG_MASK;
    end
    flg_nxt = flg_r;
    if (clrTx) begin
      flg_nxt = flg_nxt & ~(armed_r & TX_FLAG_MASK);
    end
    if (clrRx) begin
      flg_nxt = flg_nxt & ~(armed_r & RX_FLAG_MASK);
    end
    if (txTake || teRise || lastDone) begin
      flg_nxt[ST_TX_EMPTY] = 1'b1;
    end
    if (teRise || lastDone || (busyFall && !bufValid_r && txState_r == TX_ON)) begin
      flg_nxt[ST_TX_DONE] = 1'b1;
    end
    rxAccept  = rxCharReady && !sleep && !flg_r[ST_FRAMING];
    rxLoad    = rxAccept && !(flg_r[ST_RX_FULL] && !(clrRx && armed_r[ST_RX_FULL]));
    rxBuf_nxt = rxLoad ? rxCharData : rxBuf_r;
    if (rxLoad) begin
      flg_nxt[ST_RX_FULL] = 1'b1;
      flg_nxt[ST_NOISE]   = rxNoise;
      flg_nxt[ST_FRAMING] = rxFraming;
    end else if (rxAccept) begin
      flg_nxt[ST_OVERRUN] = 1'b1;
    end
    if (idleEvent && !sleep) begin
      flg_nxt[ST_IDLE] = 1'b1;
    end
    flg_nxt[0] = 1'b0;
    irq_nxt = (ctrl_r[CT_TX_EMPTY_IRQ_EN] && flg_nxt[ST_TX_EMPTY]) ||
              (ctrl_r[CT_TX_DONE_IRQ_EN] && flg_nxt[ST_TX_DONE]) ||
              (ctrl_r[CT_RX_IRQ_EN] && (flg_nxt[ST_RX_FULL] || flg_nxt[ST_OVERRUN])) ||
              (ctrl_r[CT_LINE_QUIET_IRQ_EN] && flg_nxt[ST_IDLE]);
    serialIrq = irq_r;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (sysRst) begin
      flg_r       <= 8'h00;
      armed_r     <= 8'h00;
      ctrl_r      <= CTRL_RESET;
      prescale_r  <= PRESCALE_RESET;
      rateClear_r <= 1'b0;
      rxBuf_r     <= 8'h00;
      txBuf_r     <= 8'h00;
      bufValid_r  <= 1'b0;
      busyPrev_r  <= 1'b0;
      irq_r       <= 1'b0;
      rdData_r    <= 32'h00000000;
      txState_r   <= TX_OFF;
    end else if (ce) begin
      flg_r       <= flg_nxt;
      armed_r     <= armed_nxt;
      ctrl_r      <= ctrl_nxt;
      prescale_r  <= prescale_nxt;
      rateClear_r <= rateClear_nxt;
      rxBuf_r     <= rxBuf_nxt;
      txBuf_r     <= txBuf_nxt;
      bufValid_r  <= bufValid_nxt;
      busyPrev_r  <= txLineBusy;
      irq_r       <= irq_nxt;
      rdData_r    <= rdData_nxt;
      txState_r   <= txState_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (ce) begin
      rateSel_r <= rateSel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sysRst);

  AST_TX_EMPTY_CLEAR: assert property (
    $fell(flg_r[ST_TX_EMPTY]) |-> $past(dataWr && armed_r[ST_TX_EMPTY])
  ) else $error("transmit-empty fell without the clearing sequence");

  AST_TX_DONE_CLEAR: assert property (
    $fell(flg_r[ST_TX_DONE]) |-> $past(dataWr && armed_r[ST_TX_DONE])
  ) else $error("transmit-done fell without the clearing sequence");

  AST_RX_LOAD: assert property (
    ce && rxCharReady && !sleep && !flg_r[ST_FRAMING] && !flg_r[ST_RX_FULL]
    |=> flg_r[ST_RX_FULL] && rxBuf_r == $past(rxCharData)
  ) else $error("accepted character was not loaded");

  AST_OVERRUN_KEEP: assert property (
    ce && rxCharReady && !sleep && !flg_r[ST_FRAMING] && flg_r[ST_RX_FULL] && !dataRd
    |=> flg_r[ST_OVERRUN] && $stable(rxBuf_r)
  ) else $error("overrun did not keep the old byte");

  AST_SLEEP_INHIBIT: assert property (
    $rose(flg_r[ST_RX_FULL]) || $rose(flg_r[ST_IDLE]) || $rose(flg_r[ST_OVERRUN])
    |-> !$past(sleep)
  ) else $error("receive flag set while sleeping");

  AST_FRAMING_BLOCK: assert property (
    flg_r[ST_FRAMING] ##1 flg_r[ST_FRAMING] |-> $stable(rxBuf_r)
  ) else $error("buffer changed while framing flag set");

  AST_IRQ_RX: assert property (
    ce && ctrl_r[CT_RX_IRQ_EN] && flg_r[ST_RX_FULL] && !dataRd ##1 ce |-> serialIrq
  ) else $error("receive-full did not request an interrupt");

  AST_NO_ERR_IRQ: assert property (
    ce && (flg_nxt & IRQ_FLAG_MASK) == 8'h00 |=> !serialIrq
  ) else $error("interrupt without an interrupting flag");

  AST_DRAIN_HOLD: assert property (
    txState_r == TX_DRAIN && txLineBusy |=> txPinOwn
  ) else $error("pin released before the character finished");

  COV_TX_ENABLE: cover property (txState_r == TX_OFF ##1 txState_r == TX_ON);
  COV_OVERRUN:   cover property ($rose(flg_r[ST_OVERRUN]));
  COV_IDLE:      cover property ($rose(flg_r[ST_IDLE]));
  COV_DRAIN:     cover property (txState_r == TX_DRAIN ##1 txState_r == TX_OFF);

endmodule

// *** design/serial_pkg.sv ***
/*
  Shared constants for the serial flag and bit-rate block: register
  offsets, field positions, reset values, divisors and states.
  Assumes a 32-bit APB slave with byte addresses in an 8-bit window.
*/
package serial_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DATA   = 8'h04;
  localparam logic [7:0] ADDR_RATE   = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0C;

  // serial_status_flags bit positions.
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_IDLE     = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAMING  = 1;
  localparam logic [7:0] TX_FLAG_MASK  = 8'hC0;
  localparam logic [7:0] RX_FLAG_MASK  = 8'h3E;
  localparam logic [7:0] IRQ_FLAG_MASK = 8'hF8;

  // Control register bit positions.
  localparam int CT_TX_EMPTY_IRQ_EN   = 7;
  localparam int CT_TX_DONE_IRQ_EN    = 6;
  localparam int CT_RX_IRQ_EN         = 5;
  localparam int CT_LINE_QUIET_IRQ_EN = 4;
  localparam int CT_TX_ENABLE         = 3;
  localparam int CT_RECEIVER_SLEEP    = 1;
  localparam logic [7:0] CTRL_RESET   = 8'h00;

  // serial_rate_select field positions.
  localparam int RT_COUNTER_CLEAR = 7;
  localparam int RT_PRESCALE_LO   = 4;
  localparam int RT_DIVIDER_LO    = 0;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;

  // Prescale divisors for codes 00, 01, 10 and 11.
  localparam logic [3:0] PRE_DIV_0 = 4'h1;
  localparam logic [3:0] PRE_DIV_1 = 4'h3;
  localparam logic [3:0] PRE_DIV_2 = 4'h4;
  localparam logic [3:0] PRE_DIV_3 = 4'hD;

  // Character framing counts.
  localparam int SAMPLES_PER_BIT = 16;
  localparam int CHAR_BITS       = 10;
  localparam int CHAR_SAMPLES    = SAMPLES_PER_BIT * CHAR_BITS;

  typedef enum logic [1:0] {TX_OFF, TX_ON, TX_DRAIN} tx_state_t;

endpackage

// *** design/baud_rate_gen.sv ***
/*
  Bit-rate chain: prescaler, binary divider to the 16x sample tick,
  then divide by 16 to the bit tick.
  Assumes select inputs are held stable by software during transfers.
*/
`timescale 1ns/10ps
module baud_rate_gen #(
  parameter int RATE_BITS = 3
) (
  // Clocking
  input  wire logic       clock,
  input  wire logic       sysRst,
  input  wire logic       ce,
  // Selection
  input  wire logic       counterClear,
  input  wire logic [1:0] prescaleSel,
  input  wire logic [RATE_BITS-1:0] rateSel,
  // Ticks
  output logic            sampleTick,
  output logic            bitTick
);
  import serial_pkg::*;

  if (RATE_BITS != 3) begin : g_chk
    $error("baud_rate_gen supports only a three-bit rate select");
  end

  logic [3:0] preCnt_r;
  logic [3:0] preCnt_nxt;
  logic [6:0] rateCnt_r;
  logic [6:0] rateCnt_nxt;
  logic [3:0] smpCnt_r;
  logic [3:0] smpCnt_nxt;
  logic [3:0] preLimit;
  logic [6:0] rateMask;
  logic       preTick;

  always_comb begin
    case (prescaleSel)
      2'h0: preLimit = PRE_DIV_0;
      2'h1: preLimit = PRE_DIV_1;
      2'h2: preLimit = PRE_DIV_2;
      default: preLimit = PRE_DIV_3;
    endcase
    preTick  = (preCnt_r == 4'(preLimit - 4'h1));
    rateMask = 7'((8'h01 << rateSel) - 8'h01);
    sampleTick = preTick && ((rateCnt_r & rateMask) == rateMask);
    bitTick    = sampleTick && (smpCnt_r == 4'hF);
    preCnt_nxt  = preTick ? 4'h0 : 4'(preCnt_r + 4'h1);
    rateCnt_nxt = preTick ? 7'(rateCnt_r + 7'h01) : rateCnt_r;
    smpCnt_nxt  = sampleTick ? 4'(smpCnt_r + 4'h1) : smpCnt_r;
    if (counterClear) begin
      preCnt_nxt  = 4'h0;
      rateCnt_nxt = 7'h00;
      smpCnt_nxt  = 4'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (sysRst) begin
      preCnt_r  <= 4'h0;
      rateCnt_r <= 7'h00;
      smpCnt_r  <= 4'h0;
    end else if (ce) begin
      preCnt_r  <= preCnt_nxt;
      rateCnt_r <= rateCnt_nxt;
      smpCnt_r  <= smpCnt_nxt;
    end
  end

endmodule

// *** design/line_idle_detect.sv ***
/*
  Receive-line idle detector: one pulse when the line has been high for
  a full character after having been active.
  Assumes rxLine is synchronous to clock and sampleTick is the 16x tick.
*/
`timescale 1ns/10ps
module line_idle_detect #(
  parameter int CHAR_TICKS = serial_pkg::CHAR_SAMPLES
) (
  // Clocking
  input  wire logic clock,
  input  wire logic sysRst,
  input  wire logic ce,
  // Line
  input  wire logic sampleTick,
  input  wire logic rxLine,
  // Event
  output logic      idleEvent
);
  import serial_pkg::*;

  if (CHAR_TICKS < 2 || CHAR_TICKS > 255) begin : g_chk
    $error("line_idle_detect needs CHAR_TICKS between 2 and 255");
  end

  localparam logic [7:0] LAST = 8'(CHAR_TICKS - 1);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       busy_r;
  logic       busy_nxt;

  always_comb begin
    idleEvent = busy_r && rxLine && sampleTick && (cnt_r == LAST);
    cnt_nxt   = cnt_r;
    busy_nxt  = busy_r;
    if (!rxLine) begin
      cnt_nxt  = 8'h00;
      busy_nxt = 1'b1;
    end else if (idleEvent) begin
      busy_nxt = 1'b0;
    end else if (sampleTick && cnt_r != LAST) begin
      cnt_nxt = 8'(cnt_r + 8'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (sysRst) begin
      cnt_r  <= 8'h00;
      busy_r <= 1'b0;
    end else if (ce) begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

endmodule

// *** sim/serial_partner.sv ***
/*
  Far-side model: the transmit shifter and the receive shifter of the port.
  Assumes bitTick from the block paces the received frames.
*/
`timescale 1ns/10ps
module serial_partner #(
  parameter int TX_CYC = 40
) (
  // Clocking
  input  wire logic       clock,
  input  wire logic       sysRst,
  input  wire logic       bitTick,
  // Transmit side
  input  wire logic       txDataValid,
  input  wire logic [7:0] txData,
  output logic            txTake,
  output logic            txLineBusy,
  output logic [7:0]      txSeen,
  // Receive side
  input  wire logic       rxGo,
  input  wire logic [7:0] rxByte,
  input  wire logic       rxNz,
  input  wire logic       rxFe,
  output logic            rxLine,
  output logic            rxCharReady,
  output logic [7:0]      rxCharData,
  output logic            rxNoise,
  output logic            rxFraming
);
  int         busy;
  logic [9:0] frame;
  logic [3:0] left;
  logic       rdy;

  assign txLineBusy = busy != 0;
  assign rxLine = (left != 4'h0) ? frame[0] : 1'b1;
  assign rxCharReady = rdy;
  // Outside the ready cycle the qualified lines change, so stale data cannot pass.
  assign rxCharData = rdy ? rxByte : ~rxByte;
  assign rxNoise = rdy ? rxNz : ~rxNz;
  assign rxFraming = rdy ? rxFe : ~rxFe;

  always_ff @(posedge clock) begin
    txTake <= 1'b0;
    rdy <= 1'b0;
    if (sysRst) begin
      busy <= 0;
      left <= 4'h0;
      txSeen <= 8'h00;
    end else begin
      if (busy != 0) begin
        busy <= busy - 1;
      end else if (txDataValid && !txTake) begin
        txTake <= 1'b1;
        txSeen <= txData;
        busy <= TX_CYC;
      end
      if (rxGo) begin
        frame <= {~rxFe, rxByte, 1'b0};
        left <= 4'hA;
      end else if (bitTick && left != 4'h0) begin
        frame <= {1'b1, frame[9:1]};
        left <= left - 4'h1;
        rdy <= left == 4'h1;
      end
    end
  end
endmodule

// *** sim/tb.sv ***
/*
  Self-checking bench: APB register tasks plus a shifter partner model.
  Assumes the hand-over timing: zero wait states, flags visible one edge later.
*/
`timescale 1ns/10ps
module tb;
  import serial_pkg::*;
  logic clock, sysRst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [7:0]  paddr, txData, txSeen, rxByte, rxCharData;
  logic [31:0] pwdata, prdata, rdat;
  logic txLineBusy, txTake, txDataValid, txPinOwn, rxLine, rxCharReady;
  logic rxNoise, rxFraming, sampleTick, bitTick, serialIrq, rxGo, rxNz, rxFe;
  int   fail_count, cmp_count;
  logic [7:0] rsel [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h03, 8'h17, 8'h01};
  int   rexp [7] = '{1, 3, 4, 13, 8, 384, 32};

  async_serial_flags_baud dut (.clock(clock), .sysRst(sysRst), .ce(1'b1),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txLineBusy(txLineBusy),
    .txTake(txTake), .txDataValid(txDataValid), .txData(txData), .txPinOwn(txPinOwn),
    .rxLine(rxLine), .rxCharReady(rxCharReady), .rxCharData(rxCharData),
    .rxNoise(rxNoise), .rxFraming(rxFraming), .sampleTick(sampleTick),
    .bitTick(bitTick), .serialIrq(serialIrq));
  serial_partner partner (.clock(clock), .sysRst(sysRst), .bitTick(bitTick),
    .txDataValid(txDataValid), .txData(txData), .txTake(txTake),
    .txLineBusy(txLineBusy), .txSeen(txSeen), .rxGo(rxGo), .rxByte(rxByte),
    .rxNz(rxNz), .rxFe(rxFe), .rxLine(rxLine), .rxCharReady(rxCharReady),
    .rxCharData(rxCharData), .rxNoise(rxNoise), .rxFraming(rxFraming));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    $display("Error at %0t: wait bound used up", $time);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    rdat = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdat, {24'h0, e}, {24'hFFFFFF, m});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic irq(input logic e);
    repeat (2) @(posedge clock);
    chk({31'h0, serialIrq}, {31'h0, e}, 32'h1);
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return txLineBusy === 1'b0;
      1: return txPinOwn === 1'b0;
      default: return rxCharReady === 1'b1;
    endcase
  endfunction
  task automatic waitfor(input int s, input int lim);
    int n;
    n = 0;
    while (!cond(s) && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (!cond(s)) tmo();
  endtask
  task automatic send(input logic [7:0] b, input logic nz, input logic fe);
    @(posedge clock);
    rxGo <= 1'b1;
    rxByte <= b;
    rxNz <= nz;
    rxFe <= fe;
    @(posedge clock);
    rxGo <= 1'b0;
    waitfor(2, 400);
    @(posedge clock);
  endtask
  task automatic per(input logic b, input int e);
    int n;
    int t;
    n = 0;
    t = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((b ? bitTick : sampleTick) !== 1'b1 && n < 2000);
    do begin
      @(posedge clock);
      t++;
    end while ((b ? bitTick : sampleTick) !== 1'b1 && t < 2000);
    chk(t, e, 32'hFFFFFFFF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    tmo();
  end
  initial begin
    fail_count = 0;
    cmp_count = 0;
    sysRst = 1'b1;
    {psel, penable, pwrite, rxGo, rxNz, rxFe} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rxByte = 8'h00;
    repeat (20) @(posedge clock);
    sysRst <= 1'b0;
    wr(ADDR_RATE, 8'h35);
    @(posedge clock);
    sysRst <= 1'b1;
    repeat (2) @(posedge clock);
    sysRst <= 1'b0;
    rd(ADDR_RATE, 8'h05, 8'h37);
    rd(ADDR_STATUS, 8'h00, 8'hFF);
    rd(ADDR_CTRL, 8'h00, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    chk({31'h0, lastErr}, 32'h1, 32'h1);
    // Rate changes happen only while no character is moving.
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_RATE, rsel[i]);
      per(i == 6, rexp[i]);
    end
    wr(ADDR_RATE, 8'h80);
    // Held divider counters give no bit tick within the wait bound.
    per(1'b1, 2000);
    wr(ADDR_RATE, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    rd(ADDR_STATUS, 8'hC0, 8'hC0);
    wr(ADDR_CTRL, 8'h88);
    irq(1'b1);
    wr(ADDR_CTRL, 8'h48);
    irq(1'b1);
    wr(ADDR_CTRL, 8'h08);
    irq(1'b0);
    rd(ADDR_STATUS, 8'hC0, 8'hC0);
    wr(ADDR_DATA, 8'h5A);
    repeat (3) @(posedge clock);
    rd(ADDR_STATUS, 8'h80, 8'hC0);
    chk({24'h0, txSeen}, 32'h5A, 32'hFF);
    wr(ADDR_DATA, 8'h6B);
    rd(ADDR_STATUS, 8'h00, 8'hC0);
    waitfor(0, 100);
    repeat (3) @(posedge clock);
    chk({24'h0, txSeen}, 32'h6B, 32'hFF);
    rd(ADDR_STATUS, 8'h80, 8'hC0);
    wr(ADDR_DATA, 8'h7C);
    wr(ADDR_CTRL, 8'h00);
    chk({31'h0, txPinOwn}, 32'h1, 32'h1);
    waitfor(0, 100);
    repeat (3) @(posedge clock);
    chk({24'h0, txSeen}, 32'h6B, 32'hFF);
    rd(ADDR_STATUS, 8'hC0, 8'hC0);
    waitfor(1, 40);
    wr(ADDR_CTRL, 8'h08);
    repeat (3) @(posedge clock);
    wr(ADDR_CTRL, 8'h00);
    waitfor(1, 20);
    wr(ADDR_CTRL, 8'h20);
    send(8'hA5, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'h20, 8'h2E);
    irq(1'b1);
    send(8'h3C, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'h28, 8'h2E);
    rd(ADDR_DATA, 8'hA5, 8'hFF);
    rd(ADDR_STATUS, 8'h00, 8'h2E);
    irq(1'b0);
    wr(ADDR_CTRL, 8'h00);
    send(8'h11, 1'b1, 1'b0);
    rd(ADDR_STATUS, 8'h24, 8'h2E);
    irq(1'b0);
    rd(ADDR_DATA, 8'h11, 8'hFF);
    send(8'h22, 1'b0, 1'b1);
    rd(ADDR_STATUS, 8'h22, 8'h2E);
    send(8'h33, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'h22, 8'h2E);
    rd(ADDR_DATA, 8'h22, 8'hFF);
    rd(ADDR_STATUS, 8'h00, 8'h2E);
    wr(ADDR_CTRL, 8'h02);
    send(8'h44, 1'b1, 1'b1);
    rd(ADDR_STATUS, 8'h00, 8'h2E);
    wr(ADDR_CTRL, 8'h10);
    send(8'h0F, 1'b0, 1'b0);
    repeat (100) @(posedge clock);
    rd(ADDR_STATUS, 8'h00, 8'h10);
    repeat (80) @(posedge clock);
    rd(ADDR_STATUS, 8'h30, 8'h30);
    irq(1'b1);
    rd(ADDR_DATA, 8'h0F, 8'hFF);
    repeat (300) @(posedge clock);
    rd(ADDR_STATUS, 8'h00, 8'h30);
    irq(1'b0);
    stop_test();
  end
endmodule
